// [src/gscl_pkg.sv]
package gscl_pkg;

	// ****************************************
	// Geometry
	// ****************************************
	localparam int NUM_CH = 32;
	localparam int CODE_W = 7;
	localparam int IDX_W = 5;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_W = IDX_W + CODE_W;
	localparam int SYNC_W = 3 + 3 + CODE_W;

	// ****************************************
	// Channel order and reset values
	// ****************************************
	localparam logic [IDX_W-1:0] CH_LOW = 5'h00;
	localparam logic [IDX_W-1:0] CH_HIGH = 5'h1f;
	localparam logic [IDX_W-1:0] CH_STEP = 5'h01;
	localparam logic [CODE_W-1:0] CODE_RST = 7'h00;
	localparam logic [CODE_W-1:0] CNT_RST = 7'h00;
	localparam logic [CODE_W-1:0] CNT_MAX = 7'h7f;
	localparam logic [CODE_W-1:0] CNT_STEP = 7'h01;
	localparam logic [SYNC_W-1:0] SYNC_RST = 13'h0000;

	// ****************************************
	// State encodings
	// ****************************************
	typedef enum logic [0:0] {
		GSCL_LD_IDLE = 1'b0,
		GSCL_LD_RUN = 1'b1
	} gscl_load_t;

	typedef enum logic [1:0] {
		GSCL_CV_IDLE = 2'b00,
		GSCL_CV_HOLD = 2'b01,
		GSCL_CV_COUNT = 2'b10
	} gscl_conv_t;

endpackage

// [src/gscl_fifo.sv]
module gscl_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_FULL = DEPTH[AW:0];

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	assign in_ready = (count_r != CNT_FULL);
	assign out_valid = (count_r != '0);
	assign out_data = mem_r[rd_ptr_r];

	// ****************************************
	// Storage
	// ****************************************
	// The array has no reset so it maps onto plain storage; empty hides stale words.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule // gscl_fifo

// [src/gscl_top.sv]
module gscl_top #(
	parameter int NUM_CH = gscl_pkg::NUM_CH,
	parameter int FIFO_DEPTH = gscl_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic dir_select,
	input wire logic token_a_in,
	output logic token_a_out,
	output logic token_a_oe,
	input wire logic token_b_in,
	output logic token_b_out,
	output logic token_b_oe,
	input wire logic shift_clock,
	input wire logic [gscl_pkg::CODE_W-1:0] gray_code_bus,
	input wire logic load_count_strobe,
	input wire logic count_clock,
	output logic [NUM_CH-1:0] column_output,
	output logic [gscl_pkg::CODE_W-1:0] count_value,
	output logic conversion_active,
	output logic capture_ready
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [gscl_pkg::SYNC_W-1:0] sync1_r;
	logic [gscl_pkg::SYNC_W-1:0] sync2_r;
	logic [2:0] edge_prev_r;

	// The bus shares the clock's two-stage path, so its delay matches the shift edge it pairs with.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r <= gscl_pkg::SYNC_RST;
			sync2_r <= gscl_pkg::SYNC_RST;
			edge_prev_r <= 3'h0;
		end else begin
			sync1_r <= {dir_select, token_a_in, token_b_in, shift_clock, load_count_strobe, count_clock, gray_code_bus};
			sync2_r <= sync1_r;
			edge_prev_r <= sync2_r[9:7];
		end
	end

	wire dir_s = sync2_r[12];
	wire tok_a_s = sync2_r[11];
	wire tok_b_s = sync2_r[10];
	wire sc_s = sync2_r[9];
	wire lc_s = sync2_r[8];
	wire cc_s = sync2_r[7];
	// Bit six carries the most significant code bit.
	wire [gscl_pkg::CODE_W-1:0] bus_s = sync2_r[gscl_pkg::CODE_W-1:0];
	wire sc_rise = sc_s & ~edge_prev_r[2];
	wire sc_fall = ~sc_s & edge_prev_r[2];
	wire sc_edge = sc_rise | sc_fall;
	wire lc_rise = lc_s & ~edge_prev_r[1];
	wire lc_fall = ~lc_s & edge_prev_r[1];
	wire cc_rise = cc_s & ~edge_prev_r[0];

	// ****************************************
	// Token path and capture
	// ****************************************
	gscl_pkg::gscl_load_t ld_r;
	gscl_pkg::gscl_load_t ld_nxt;
	logic [gscl_pkg::IDX_W-1:0] ptr_r;
	logic [gscl_pkg::IDX_W-1:0] ptr_nxt;
	logic exit_r;
	logic exit_nxt;

	wire token_in = dir_s ? tok_a_s : tok_b_s;
	wire [gscl_pkg::IDX_W-1:0] ch_first = dir_s ? gscl_pkg::CH_LOW : gscl_pkg::CH_HIGH;
	wire [gscl_pkg::IDX_W-1:0] ch_last = dir_s ? gscl_pkg::CH_HIGH : gscl_pkg::CH_LOW;
	wire start_cap = (ld_r == gscl_pkg::GSCL_LD_IDLE) & sc_rise & token_in;
	wire run_cap = (ld_r == gscl_pkg::GSCL_LD_RUN) & sc_edge;
	wire capture = start_cap | run_cap;
	wire [gscl_pkg::IDX_W-1:0] cap_idx = start_cap ? ch_first : ptr_r;
	wire [gscl_pkg::IDX_W-1:0] idx_up = cap_idx + gscl_pkg::CH_STEP;
	wire [gscl_pkg::IDX_W-1:0] idx_down = cap_idx - gscl_pkg::CH_STEP;
	wire [gscl_pkg::IDX_W-1:0] idx_next = dir_s ? idx_up : idx_down;
	wire last_cap = run_cap & (ptr_r == ch_last);

	always_comb begin
		ld_nxt = ld_r;
		ptr_nxt = ptr_r;
		exit_nxt = exit_r;
		if (exit_r && sc_rise) begin
			exit_nxt = 1'b0;
		end
		case (ld_r)
			gscl_pkg::GSCL_LD_IDLE: begin
				if (start_cap) begin
					ld_nxt = gscl_pkg::GSCL_LD_RUN;
					ptr_nxt = idx_next;
				end
			end
			gscl_pkg::GSCL_LD_RUN: begin
				if (last_cap) begin
					ld_nxt = gscl_pkg::GSCL_LD_IDLE;
					exit_nxt = 1'b1;
				end else if (run_cap) begin
					ptr_nxt = idx_next;
				end
			end
			default: begin
				ld_nxt = gscl_pkg::GSCL_LD_IDLE;
			end
		endcase
	end

	// The exit token stays up until the next rising shift edge, which is the one the next chip samples.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ld_r <= gscl_pkg::GSCL_LD_IDLE;
			ptr_r <= gscl_pkg::CH_LOW;
			exit_r <= 1'b0;
		end else begin
			ld_r <= ld_nxt;
			ptr_r <= ptr_nxt;
			exit_r <= exit_nxt;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			token_a_out <= 1'b0;
			token_a_oe <= 1'b0;
			token_b_out <= 1'b0;
			token_b_oe <= 1'b0;
		end else begin
			token_a_out <= ~dir_s & exit_nxt;
			token_a_oe <= ~dir_s;
			token_b_out <= dir_s & exit_nxt;
			token_b_oe <= dir_s;
		end
	end

	// ****************************************
	// Capture buffer
	// ****************************************
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [gscl_pkg::FIFO_W-1:0] fifo_out_data;

	// Draining pauses while load-count is high so the copy sees a settled latch set.
	wire drain_ready = ~lc_s;
	wire drain = fifo_out_valid & drain_ready;
	wire [gscl_pkg::IDX_W-1:0] drain_idx = fifo_out_data[gscl_pkg::FIFO_W-1:gscl_pkg::CODE_W];
	wire [gscl_pkg::CODE_W-1:0] drain_code = fifo_out_data[gscl_pkg::CODE_W-1:0];

	gscl_fifo #(
		.WIDTH(gscl_pkg::FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(capture),
		.in_ready(fifo_in_ready),
		.in_data({cap_idx, bus_s}),
		.out_valid(fifo_out_valid),
		.out_ready(drain_ready),
		.out_data(fifo_out_data)
	);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			capture_ready <= 1'b1;
		end else begin
			capture_ready <= fifo_in_ready;
		end
	end

	// ****************************************
	// Conversion control
	// ****************************************
	gscl_pkg::gscl_conv_t cv_r;
	gscl_pkg::gscl_conv_t cv_nxt;
	logic [gscl_pkg::CODE_W-1:0] cnt_r;
	logic [gscl_pkg::CODE_W-1:0] cnt_nxt;

	wire cnt_step = (cv_r == gscl_pkg::GSCL_CV_COUNT) & cc_rise & (cnt_r != gscl_pkg::CNT_MAX);
	wire conv_start = (cv_r == gscl_pkg::GSCL_CV_HOLD) & lc_fall;

	always_comb begin
		cv_nxt = cv_r;
		cnt_nxt = cnt_r;
		case (cv_r)
			gscl_pkg::GSCL_CV_IDLE, gscl_pkg::GSCL_CV_COUNT: begin
				if (cnt_step) begin
					cnt_nxt = cnt_r + gscl_pkg::CNT_STEP;
				end
			end
			gscl_pkg::GSCL_CV_HOLD: begin
				if (conv_start) begin
					cv_nxt = gscl_pkg::GSCL_CV_COUNT;
				end
			end
			default: begin
				cv_nxt = gscl_pkg::GSCL_CV_IDLE;
			end
		endcase
		if (lc_rise) begin
			cv_nxt = gscl_pkg::GSCL_CV_HOLD;
			cnt_nxt = gscl_pkg::CNT_RST;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cv_r <= gscl_pkg::GSCL_CV_IDLE;
			cnt_r <= gscl_pkg::CNT_RST;
			count_value <= gscl_pkg::CNT_RST;
			conversion_active <= 1'b0;
		end else begin
			cv_r <= cv_nxt;
			cnt_r <= cnt_nxt;
			count_value <= cnt_nxt;
			conversion_active <= (cv_nxt == gscl_pkg::GSCL_CV_COUNT);
		end
	end

	// ****************************************
	// Per-channel latches and comparators
	// ****************************************
	// A channel that has stopped stays stopped; the hold capacitor keeps its level.
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		logic [gscl_pkg::CODE_W-1:0] data_r;
		logic [gscl_pkg::CODE_W-1:0] cmp_r;
		wire hit = drain & (drain_idx == i[gscl_pkg::IDX_W-1:0]);
		wire match = (cmp_r == cnt_nxt);
		wire col_nxt = lc_rise ? 1'b0 :
			conv_start ? ~match :
			(cv_r == gscl_pkg::GSCL_CV_COUNT) ? column_output[i] & ~match : column_output[i];

		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				data_r <= gscl_pkg::CODE_RST;
				cmp_r <= gscl_pkg::CODE_RST;
				column_output[i] <= 1'b0;
			end else begin
				if (hit) begin
					data_r <= drain_code;
				end
				if (lc_rise) begin
					cmp_r <= data_r;
				end
				column_output[i] <= col_nxt;
			end
		end
	end

endmodule // gscl_top

// [bench/gscl_top_assertions.sv]
module gscl_top_assertions #(
	parameter int NUM_CH = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic dir_select,
	input wire logic token_a_out,
	input wire logic token_a_oe,
	input wire logic token_b_out,
	input wire logic token_b_oe,
	input wire logic load_count_strobe,
	input wire logic [NUM_CH-1:0] column_output,
	input wire logic [gscl_pkg::CODE_W-1:0] count_value,
	input wire logic conversion_active
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Checks
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_cleared;
		column_output == '0 && count_value == 7'h00 && !conversion_active;
	endsequence
	a_oe_dir: assert property ($stable(dir_select) [*4] |-> token_b_oe == dir_select && token_a_oe != dir_select)
		else $error("select enable wrong");
	a_exit_drv: assert property (!(token_a_out && !token_a_oe) && !(token_b_out && !token_b_oe))
		else $error("token driven on entry pin");
	a_lc_clear: assert property ($rose(load_count_strobe) |-> ##[2:4] s_cleared)
		else $error("no clear on load");
	a_conv_start: assert property ($fell(load_count_strobe) |-> ##[2:4] conversion_active)
		else $error("no conversion start");
	a_count_step: assert property ($changed(count_value) |-> count_value == $past(count_value) + 7'h01 || count_value == 7'h00)
		else $error("count jump");
	a_count_sat: assert property (count_value == 7'h7f && conversion_active |=> count_value == 7'h7f || !conversion_active)
		else $error("count wrapped");
	a_count_idle: assert property ($changed(count_value) && count_value != 7'h00 |-> conversion_active)
		else $error("count while idle");
	a_col_idle: assert property (!conversion_active |-> column_output == '0)
		else $error("charging while idle");
	a_col_hold: assert property (conversion_active && $past(conversion_active) |-> (column_output & ~$past(column_output)) == '0)
		else $error("channel restarted");
	a_col_max: assert property (count_value == 7'h7f |-> column_output == '0)
		else $error("channel still charging at top");
endmodule // gscl_top_assertions

bind gscl_top gscl_top_assertions #(.NUM_CH(NUM_CH)) u_gscl_top_assertions (.clk(clk), .sys_rst(sys_rst),
	.dir_select(dir_select), .token_a_out(token_a_out), .token_a_oe(token_a_oe), .token_b_out(token_b_out),
	.token_b_oe(token_b_oe), .load_count_strobe(load_count_strobe), .column_output(column_output),
	.count_value(count_value), .conversion_active(conversion_active));

// [bench/gscl_ctrl_model.sv]
module gscl_ctrl_model (
	input wire logic clk,
	output logic dir_select,
	output logic tok_a_drv,
	output logic tok_b_drv,
	output logic shift_clock,
	output logic [gscl_pkg::CODE_W-1:0] gray_code_bus,
	output logic load_count_strobe,
	output logic count_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Controller
	// ****
	logic tok;
	assign tok_a_drv = dir_select & tok;
	assign tok_b_drv = !dir_select & tok;
	initial begin
		dir_select = 1'b1;
		tok = 1'b0;
		shift_clock = 1'b0;
		gray_code_bus = 7'h00;
		load_count_strobe = 1'b0;
		count_clock = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic load_line(input logic dir, input logic [gscl_pkg::CODE_W-1:0] seq [gscl_pkg::NUM_CH]);
		dir_select = dir;
		tick(6);
		tok = 1'b1;
		for (int k = 0; k < gscl_pkg::NUM_CH; k++) begin
			gray_code_bus = seq[k];
			tick(2);
			shift_clock = !shift_clock;
			tick(2);
			tok = 1'b0;
		end
		// The bus is left at the complement of the last code so a late sample cannot match by luck.
		gray_code_bus = ~seq[gscl_pkg::NUM_CH-1];
		tick(3);
	endtask
	task automatic stray_edges();
		repeat (2) begin
			tick(4);
			shift_clock = !shift_clock;
		end
		tick(4);
	endtask
	task automatic start_conv();
		load_count_strobe = 1'b1;
		tick(3);
		load_count_strobe = 1'b0;
		tick(15);
	endtask
	task automatic count_pulse();
		count_clock = 1'b1;
		tick(2);
		count_clock = 1'b0;
		tick(2);
	endtask
endmodule // gscl_ctrl_model

// [bench/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Bench
	// ****
	logic clk, sys_rst, dir_select, tok_a_drv, tok_b_drv, shift_clock, load_count_strobe, count_clock;
	logic token_a_in, token_a_out, token_a_oe, token_b_in, token_b_out, token_b_oe, conversion_active, capture_ready;
	logic [gscl_pkg::CODE_W-1:0] gray_code_bus, count_value;
	logic [gscl_pkg::NUM_CH-1:0] column_output;
	logic [6:0] line_a [32], line_b [32], ch_a [32], ch_b [32];
	int num_errors, checks;
	assign token_a_in = token_a_oe ? token_a_out : tok_a_drv;
	assign token_b_in = token_b_oe ? token_b_out : tok_b_drv;
	gscl_top u_gscl_top (.clk(clk), .sys_rst(sys_rst), .dir_select(dir_select), .token_a_in(token_a_in),
		.token_a_out(token_a_out), .token_a_oe(token_a_oe), .token_b_in(token_b_in), .token_b_out(token_b_out),
		.token_b_oe(token_b_oe), .shift_clock(shift_clock), .gray_code_bus(gray_code_bus),
		.load_count_strobe(load_count_strobe), .count_clock(count_clock), .column_output(column_output),
		.count_value(count_value), .conversion_active(conversion_active), .capture_ready(capture_ready));
	gscl_ctrl_model u_gscl_ctrl_model (.clk(clk), .dir_select(dir_select), .tok_a_drv(tok_a_drv),
		.tok_b_drv(tok_b_drv), .shift_clock(shift_clock), .gray_code_bus(gray_code_bus),
		.load_count_strobe(load_count_strobe), .count_clock(count_clock));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d, errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// A channel charges while the counter is below its code, so code 0 never charges.
	function automatic logic [31:0] exp_cols(input logic [6:0] ch [32], input int cnt);
		for (int i = 0; i < 32; i++) begin
			exp_cols[i] = (ch[i] > cnt);
		end
	endfunction
	task automatic convert_and_check(input logic [6:0] ch [32]);
		check("columns at start", exp_cols(ch, 0), column_output);
		for (int c = 1; c <= 130; c++) begin
			u_gscl_ctrl_model.count_pulse();
			check("count", (c > 127) ? 127 : c, count_value);
			check("columns", exp_cols(ch, c), column_output);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (6000) @(posedge clk);
		num_errors++;
		$display("unexpected timeout: expected finish, seen hang");
		wrap_up();
	end
	initial begin
		sys_rst = 1'b1;
		num_errors = 0;
		checks = 0;
		void'($urandom(66863));
		for (int k = 0; k < 32; k++) begin
			line_a[k] = 7'($urandom_range(127));
			line_b[k] = 7'($urandom_range(127));
		end
		line_a[0] = 7'h00;
		line_a[1] = 7'h7f;
		line_a[31] = 7'h01;
		line_b[0] = 7'h7f;
		line_b[31] = 7'h40;
		for (int k = 0; k < 32; k++) begin
			ch_a[k] = line_a[k];
			ch_b[31-k] = line_b[k];
		end
		repeat (2) @(negedge clk);
		check("reset columns", 0, column_output);
		check("room", 1, capture_ready);
		sys_rst = 1'b0;
		u_gscl_ctrl_model.load_line(1'b1, line_a);
		check("exit token b", 1, token_b_out);
		check("entry token a", 0, token_a_out);
		u_gscl_ctrl_model.start_conv();
		u_gscl_ctrl_model.stray_edges();
		check("exit token b cleared", 0, token_b_out);
		check("room after load", 1, capture_ready);
		u_gscl_ctrl_model.load_line(1'b0, line_b);
		check("exit token a", 1, token_a_out);
		convert_and_check(ch_a);
		u_gscl_ctrl_model.start_conv();
		convert_and_check(ch_b);
		wrap_up();
	end
endmodule // tb
